// ---- common/smi_routing_pkg.sv ----
// package for the management-interrupt source routing block
// assumes an 8-bit register port with byte-wide register indices
`default_nettype none
package smi_routing_pkg;
	// register indices
	localparam logic [7:0] OFS_ENABLE_ONE = 8'hb4;
	localparam logic [7:0] OFS_ENABLE_TWO = 8'hb5;
	localparam logic [7:0] OFS_STATUS_ONE = 8'hb6;
	localparam logic [7:0] OFS_STATUS_TWO = 8'hb7;
	localparam logic [7:0] OFS_KBD_RST_GATE = 8'hf0;
	localparam logic [7:0] OFS_EVT_STATUS = 8'hc8;
	localparam logic [7:0] OFS_EVT_ENABLE = 8'hc9;
	localparam logic [7:0] OFS_EVT_CLEAR = 8'hca;
	// reset values
	localparam logic [7:0] RST_ENABLE_ONE = 8'h00;
	localparam logic [7:0] RST_ENABLE_TWO = 8'h00;
	localparam logic [7:0] RST_KBD_RST_GATE = 8'h00;
	localparam logic [7:0] RST_EVT_ENABLE = 8'h00;
	// implemented bits of the first enable and status register
	localparam logic [7:0] MASK_ONE = 8'h9e;
	// implemented gate bits of the second enable register
	localparam logic [7:0] MASK_TWO = 8'h17;
	// writable bits of the second enable register (gates plus frame enable)
	localparam logic [7:0] MASK_TWO_WR = 8'h57;
	// writable bits of the keyboard reset/gate select (polarity and port 92 select)
	localparam logic [7:0] MASK_KBD_SEL = 8'h84;
	// field positions, register one
	localparam int BIT_PARPORT = 1;
	localparam int BIT_UART_B = 2;
	localparam int BIT_UART_A = 3;
	localparam int BIT_FLOPPY = 4;
	localparam int BIT_WATCHDOG = 7;
	// field positions, register two
	localparam int BIT_MOUSE = 0;
	localparam int BIT_KEYBOARD = 1;
	localparam int BIT_INFRARED = 2;
	localparam int BIT_PORTBIT = 4;
	localparam int BIT_FRAME_EN = 6;
	// field position, keyboard reset/gate select
	localparam int BIT_PORTBIT_POL = 7;
	// event bits of the interrupt status register
	localparam int EVT_GROUP_RISE = 0;
	localparam int EVT_INFRARED = 1;
	localparam int EVT_W = 2;

	// raw sources entering the block, all active high except the port bit
	typedef struct packed {
		logic parport;
		logic uart_b;
		logic uart_a;
		logic floppy;
		logic watchdog;
		logic mouse;
		logic keyboard;
		logic kbc_port1_bit2;
	} smi_src_s;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
endpackage : smi_routing_pkg
`default_nettype wire

// ---- verilog/smi_reg_word.sv ----
// one byte-wide control register with write mask and reset value
// assumes a synchronous active-high reset and a one-cycle write strobe
`timescale 1ns/10ps
`default_nettype none
module smi_reg_word #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WR_MASK = 8'hff
) (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_we,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_q
);
	logic [7:0] q_ff;
	wire [7:0] nxt_q = i_we ? (i_wdata & WR_MASK) : q_ff;

	// reserved bits never store, so they read back as zero
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			q_ff <= RESET_VAL & WR_MASK;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign o_q = q_ff;
endmodule : smi_reg_word
`default_nettype wire

// ---- verilog/smi_source_routing.sv ----
// management-interrupt source routing: enables, status, group output
// assumes sources synchronous to i_clk_sys; register port with one-cycle strobes
// read data stand one cycle after the read strobe; the event interrupt leaves on o_irq
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - each implemented bit of the first enable register passes its source when 1 and blocks it when 0.
// - first enable bits 1,2,3,4,7 gate parallel port, second uart, first uart, floppy, watchdog; 0,5,6 reserved.
// - the second enable register gates its sources onto the same group output with 1 enable, 0 disable.
// - second enable bits 0,1,2,4 gate mouse, keyboard, infrared activity and the port bit; 3, 5 and 7 reserved.
// - the port-bit routing enable at 0 keeps the port bit off the group output and at 1 routes it.
// - bit 6 of the second enable places the group state into the serial-irq management frame.
// - bit 7 of the keyboard reset/gate select sets port-bit polarity, 0 active low by default, 1 active high.
// - the first status register shows the raw sources at bits 1,2,3,4,7 and they clear only at source.
// - infrared status sets on any receive-line transition and clears on a read of the second status register.
module smi_source_routing
	import smi_routing_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	// register port
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// raw sources
	input wire logic i_parport_irq,
	input wire logic i_uart_b_irq,
	input wire logic i_uart_a_irq,
	input wire logic i_floppy_irq,
	input wire logic i_watchdog_irq,
	input wire logic i_mouse_irq,
	input wire logic i_keyboard_irq,
	input wire logic i_kbc_port1_bit2,
	input wire logic i_ir_rx,
	// outputs
	output logic o_group_mgmt_irq_n,
	output logic o_serirq_mgmt_frame,
	output logic o_kbc_port1_bit2_active_high,
	output logic o_irq
);
	// carriers for the raw sources and the register request
	smi_src_s src;
	reg_req_s req;

	// register images
	logic [7:0] en_one;
	logic [7:0] en_two;
	logic [7:0] kbd_sel;
	logic [7:0] rdata_ff;

	// infrared edge detector and its sticky status
	logic ir_prev_ff;
	logic ir_seen_ff;
	logic infrared_src_status_ff;

	// group line and serial frame level
	logic group_n_ff;
	logic frame_ff;

	// event status and enable behind the interrupt output
	logic [EVT_W-1:0] evt_status_ff;
	logic [EVT_W-1:0] evt_enable_ff;

	// bundle the ports so decoding reads plainly
	assign src = '{
		parport: i_parport_irq,
		uart_b: i_uart_b_irq,
		uart_a: i_uart_a_irq,
		floppy: i_floppy_irq,
		watchdog: i_watchdog_irq,
		mouse: i_mouse_irq,
		keyboard: i_keyboard_irq,
		kbc_port1_bit2: i_kbc_port1_bit2
	};
	// register port request
	assign req = '{
		addr: i_reg_addr,
		wdata: i_reg_wdata,
		wr: i_reg_wr,
		rd: i_reg_rd
	};

	// decode helper used for every strobe
	function automatic logic hit(input reg_req_s r, input logic [7:0] ofs, input logic strobe);
		hit = strobe && (r.addr == ofs);
	endfunction : hit

	// gate a status byte with its enable byte; reserved positions never pass
	function automatic logic [7:0] gate_bits(input logic [7:0] status, input logic [7:0] enable,
		input logic [7:0] mask);
		gate_bits = status & enable & mask;
	endfunction : gate_bits

	// widen an event vector to a register byte, upper bits read zero
	function automatic logic [7:0] evt_byte(input logic [EVT_W-1:0] v);
		evt_byte = {{(8-EVT_W){1'b0}}, v};
	endfunction : evt_byte

	wire wr_en_one = hit(req, OFS_ENABLE_ONE, req.wr);
	wire wr_en_two = hit(req, OFS_ENABLE_TWO, req.wr);
	wire wr_kbd_sel = hit(req, OFS_KBD_RST_GATE, req.wr);
	wire wr_evt_en = hit(req, OFS_EVT_ENABLE, req.wr);
	wire wr_evt_clr = hit(req, OFS_EVT_CLEAR, req.wr);
	wire rd_status_two = hit(req, OFS_STATUS_TWO, req.rd);

	smi_reg_word #(
		.RESET_VAL(RST_ENABLE_ONE),
		.WR_MASK(MASK_ONE)
	) u_enable_one (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(wr_en_one),
		.i_wdata(req.wdata),
		.o_q(en_one)
	);

	smi_reg_word #(
		.RESET_VAL(RST_ENABLE_TWO),
		.WR_MASK(MASK_TWO_WR)
	) u_enable_two (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(wr_en_two),
		.i_wdata(req.wdata),
		.o_q(en_two)
	);

	// only bits 7 and 2 are defined; port 92 bit is stored but unused here
	smi_reg_word #(
		.RESET_VAL(RST_KBD_RST_GATE),
		.WR_MASK(MASK_KBD_SEL)
	) u_kbd_sel (
		.i_clk_sys(i_clk_sys),
		.i_srst(i_srst),
		.i_we(wr_kbd_sel),
		.i_wdata(req.wdata),
		.o_q(kbd_sel)
	);

	wire portbit_pol_high = kbd_sel[BIT_PORTBIT_POL];
	wire portbit_active = portbit_pol_high ? src.kbc_port1_bit2 : ~src.kbc_port1_bit2;
	assign o_kbc_port1_bit2_active_high = portbit_pol_high;

	// named gate bits of the first enable
	wire parport_src_enable = en_one[BIT_PARPORT];
	wire uart_b_src_enable = en_one[BIT_UART_B];
	wire uart_a_src_enable = en_one[BIT_UART_A];
	wire floppy_src_enable = en_one[BIT_FLOPPY];
	wire watchdog_src_enable = en_one[BIT_WATCHDOG];

	// named gate bits of the second enable
	wire mouse_src_enable = en_two[BIT_MOUSE];
	wire keyboard_src_enable = en_two[BIT_KEYBOARD];
	wire infrared_src_enable = en_two[BIT_INFRARED];
	// port-bit routing enable; at 0 the port bit never reaches the group line
	wire kbc_portbit_route_enable = en_two[BIT_PORTBIT];
	// frame enable; stored with the gates but never gates a source itself
	wire serirq_mgmt_frame_enable = en_two[BIT_FRAME_EN];

	// raw first-status bits; nothing is stored, so each clears only at its source
	wire parport_src_status = src.parport;
	wire uart_b_src_status = src.uart_b;
	wire uart_a_src_status = src.uart_a;
	wire floppy_src_status = src.floppy;
	wire watchdog_src_status = src.watchdog;

	// first status byte, reserved positions stay zero
	logic [7:0] status_one;
	always_comb begin
		status_one = 8'h00;
		status_one[BIT_PARPORT] = parport_src_status;
		status_one[BIT_UART_B] = uart_b_src_status;
		status_one[BIT_UART_A] = uart_a_src_status;
		status_one[BIT_FLOPPY] = floppy_src_status;
		status_one[BIT_WATCHDOG] = watchdog_src_status;
	end

	// second status byte; the infrared bit is the only latched one
	logic [7:0] status_two;
	always_comb begin
		status_two = 8'h00;
		status_two[BIT_MOUSE] = src.mouse;
		status_two[BIT_KEYBOARD] = src.keyboard;
		status_two[BIT_INFRARED] = infrared_src_status_ff;
		status_two[BIT_PORTBIT] = portbit_active;
	end

	// gate bytes rebuilt from the named enables, each position set by its constant
	logic [7:0] gate_one;
	always_comb begin
		gate_one = 8'h00;
		gate_one[BIT_PARPORT] = parport_src_enable;
		gate_one[BIT_UART_B] = uart_b_src_enable;
		gate_one[BIT_UART_A] = uart_a_src_enable;
		gate_one[BIT_FLOPPY] = floppy_src_enable;
		gate_one[BIT_WATCHDOG] = watchdog_src_enable;
	end

	// the frame enable is left out here, it must never pull the group line
	logic [7:0] gate_two;
	always_comb begin
		gate_two = 8'h00;
		gate_two[BIT_MOUSE] = mouse_src_enable;
		gate_two[BIT_KEYBOARD] = keyboard_src_enable;
		gate_two[BIT_INFRARED] = infrared_src_enable;
		gate_two[BIT_PORTBIT] = kbc_portbit_route_enable;
	end

	// edge on the receive line; first cycle after reset is masked to avoid a false edge
	wire ir_edge = ir_seen_ff && (i_ir_rx != ir_prev_ff);

	// set wins over the read clear so an edge is never lost
	wire nxt_infrared = ir_edge ? 1'b1 : (rd_status_two ? 1'b0 : infrared_src_status_ff);

	// last level of the receive line
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			ir_prev_ff <= 1'b0;
		end else begin
			ir_prev_ff <= i_ir_rx;
		end
	end

	// the detector stays blind until one level has been seen since reset
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			ir_seen_ff <= 1'b0;
		end else begin
			ir_seen_ff <= 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			infrared_src_status_ff <= 1'b0;
		end else begin
			infrared_src_status_ff <= nxt_infrared;
		end
	end

	// gate each status bit with its enable; reserved bits are masked
	wire [7:0] gated_one = gate_bits(status_one, gate_one, MASK_ONE);
	wire [7:0] gated_two = gate_bits(status_two, gate_two, MASK_TWO);
	wire any_one = |gated_one;
	wire any_two = |gated_two;
	// any enabled active source pulls the group line low
	wire nxt_group_n = ~(any_one | any_two);
	// frame carries the group state only when enabled; active high in the frame
	wire nxt_frame = serirq_mgmt_frame_enable & ~nxt_group_n;

	// registered so the pin never glitches while sources settle
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			group_n_ff <= 1'b1;
		end else begin
			group_n_ff <= nxt_group_n;
		end
	end

	// frame level follows the group line in the same cycle
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			frame_ff <= 1'b0;
		end else begin
			frame_ff <= nxt_frame;
		end
	end

	assign o_group_mgmt_irq_n = group_n_ff;
	assign o_serirq_mgmt_frame = frame_ff;

	// sticky events: group assertion and infrared edge
	wire group_fall = group_n_ff && !nxt_group_n;
	logic [EVT_W-1:0] evt_set;
	always_comb begin
		evt_set = '0;
		evt_set[EVT_GROUP_RISE] = group_fall;
		evt_set[EVT_INFRARED] = ir_edge;
	end
	wire [EVT_W-1:0] evt_clr = wr_evt_clr ? req.wdata[EVT_W-1:0] : '0;
	// set wins over a write-one clear in the same cycle
	wire [EVT_W-1:0] nxt_evt_status = evt_set | (evt_status_ff & ~evt_clr);
	wire [EVT_W-1:0] nxt_evt_enable = wr_evt_en ? req.wdata[EVT_W-1:0] : evt_enable_ff;

	// event status, cleared only by writing ones to the clear register
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			evt_status_ff <= '0;
		end else begin
			evt_status_ff <= nxt_evt_status;
		end
	end

	// event enable, plain read/write
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			evt_enable_ff <= RST_EVT_ENABLE[EVT_W-1:0];
		end else begin
			evt_enable_ff <= nxt_evt_enable;
		end
	end

	assign o_irq = |(evt_status_ff & evt_enable_ff);

	// read mux; unmapped indices read zero, clear register is write-only
	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		unique case (req.addr)
			OFS_ENABLE_ONE: rd_mux = en_one;
			OFS_ENABLE_TWO: rd_mux = en_two;
			OFS_STATUS_ONE: rd_mux = status_one;
			OFS_STATUS_TWO: rd_mux = status_two;
			OFS_KBD_RST_GATE: rd_mux = kbd_sel;
			OFS_EVT_STATUS: rd_mux = evt_byte(evt_status_ff);
			OFS_EVT_ENABLE: rd_mux = evt_byte(evt_enable_ff);
			default: rd_mux = 8'h00;
		endcase
	end

	// read data stand one cycle after the strobe and only there
	wire [7:0] nxt_rdata = req.rd ? rd_mux : 8'h00;

	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_reg_rdata = rdata_ff;
endmodule : smi_source_routing
`default_nettype wire

// ---- testbench/smi_source_routing_props.sv ----
// port assertions for the routing block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module smi_source_routing_chk
	import smi_routing_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic i_parport_irq,
	input wire logic i_uart_b_irq,
	input wire logic i_uart_a_irq,
	input wire logic i_floppy_irq,
	input wire logic i_watchdog_irq,
	input wire logic i_mouse_irq,
	input wire logic i_keyboard_irq,
	input wire logic i_kbc_port1_bit2,
	input wire logic i_ir_rx,
	input wire logic o_group_mgmt_irq_n,
	input wire logic o_serirq_mgmt_frame,
	input wire logic o_kbc_port1_bit2_active_high
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_srst);
	// decoded strobes and the raw first-status image
	wire rd6 = i_reg_rd && i_reg_addr == OFS_STATUS_ONE;
	wire rd7 = i_reg_rd && i_reg_addr == OFS_STATUS_TWO;
	wire wkb = i_reg_wr && i_reg_addr == OFS_KBD_RST_GATE;
	wire [7:0] raw = {i_watchdog_irq, 2'b00, i_floppy_irq, i_uart_a_irq, i_uart_b_irq, i_parport_irq, 1'b0};
	wire act = |raw || i_mouse_irq || i_keyboard_irq || i_kbc_port1_bit2 == o_kbc_port1_bit2_active_high;
	property p_raw;
		rd6 && $stable(raw) |=> o_reg_rdata == $past(raw);
	endproperty
	a_raw: assert property (p_raw) else $error("status one wrong");
	property p_irclr;
		rd7 && $stable(i_ir_rx) ##1 rd7 && $stable(i_ir_rx) |=> !o_reg_rdata[2];
	endproperty
	a_irclr: assert property (p_irclr) else $error("ir status not cleared");
	property p_resv;
		rd7 |=> o_reg_rdata[7:5] == 3'b000 && !o_reg_rdata[3];
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bit set");
	property p_frame;
		o_serirq_mgmt_frame |-> !o_group_mgmt_irq_n;
	endproperty
	a_frame: assert property (p_frame) else $error("frame without group");
	property p_pol;
		wkb |=> o_kbc_port1_bit2_active_high == $past(i_reg_wdata[BIT_PORTBIT_POL]);
	endproperty
	a_pol: assert property (p_pol) else $error("polarity not taken");
	property p_polhold;
		!wkb |=> $stable(o_kbc_port1_bit2_active_high);
	endproperty
	a_polhold: assert property (p_polhold) else $error("polarity moved");
	property p_cause;
		$fell(o_group_mgmt_irq_n) |-> $past(act) || $past(i_reg_wr, 2) || $past(i_ir_rx, 2) != $past(i_ir_rx, 3);
	endproperty
	a_cause: assert property (p_cause) else $error("group without cause");
	property p_idle;
		!i_reg_rd |=> o_reg_rdata == 8'h00;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside slot");
	c_grp: cover property ($fell(o_group_mgmt_irq_n));
	c_frame: cover property (o_serirq_mgmt_frame);
	c_ir: cover property (rd7 ##1 rd7);
endmodule : smi_source_routing_chk
bind smi_source_routing smi_source_routing_chk i_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
	.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .i_parport_irq(i_parport_irq), .i_uart_b_irq(i_uart_b_irq),
	.i_uart_a_irq(i_uart_a_irq), .i_floppy_irq(i_floppy_irq), .i_watchdog_irq(i_watchdog_irq),
	.i_mouse_irq(i_mouse_irq), .i_keyboard_irq(i_keyboard_irq), .i_kbc_port1_bit2(i_kbc_port1_bit2),
	.i_ir_rx(i_ir_rx), .o_group_mgmt_irq_n(o_group_mgmt_irq_n), .o_serirq_mgmt_frame(o_serirq_mgmt_frame),
	.o_kbc_port1_bit2_active_high(o_kbc_port1_bit2_active_high));
`default_nettype wire

// ---- testbench/smi_serirq_host.sv ----
// stand-in for the host serial interrupt receiver
// assumes the frame request is a level on i_clk_sys
`timescale 1ns/10ps
`default_nettype none
module smi_serirq_host (
	input wire logic i_clk_sys,
	input wire logic i_srst,
	input wire logic i_frame,
	output logic [15:0] o_count
);
	always_ff @(posedge i_clk_sys) begin
		if (i_srst) begin
			o_count <= 16'h0000;
		end else if (i_frame) begin
			o_count <= o_count + 16'h0001;
		end
	end
endmodule : smi_serirq_host
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the routing block
// assumes 100 MHz clock, reads answered one cycle later
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import smi_routing_pkg::*;
	logic i_clk_sys = 0, i_srst = 1, wr = 0, rd = 0, rd_q = 0, ir = 0, gn, fr, ah, irq;
	logic [7:0] a = 8'h00, wd = 8'h00, s1 = 8'h00, s2 = 8'h00, rdata;
	logic [15:0] seen;
	logic [11:0] q[$];
	int failures = 0, check_count = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	smi_source_routing i_smi_source_routing (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_reg_addr(a),
		.i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_parport_irq(s1[1]),
		.i_uart_b_irq(s1[2]), .i_uart_a_irq(s1[3]), .i_floppy_irq(s1[4]), .i_watchdog_irq(s1[7]),
		.i_mouse_irq(s2[0]), .i_keyboard_irq(s2[1]), .i_kbc_port1_bit2(s2[4]), .i_ir_rx(ir),
		.o_group_mgmt_irq_n(gn), .o_serirq_mgmt_frame(fr), .o_kbc_port1_bit2_active_high(ah), .o_irq(irq));
	smi_serirq_host i_smi_serirq_host (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_frame(fr), .o_count(seen));
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic give_verdict;
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	// one bus cycle; a read notes {ah, irq, group_n, frame, data}
	task automatic op(input logic w, input logic r, input logic [7:0] ad, input logic [7:0] d, input logic [3:0] e);
		@(posedge i_clk_sys);
		wr <= w;
		rd <= r;
		a <= ad;
		wd <= d;
		if (r)
			q.push_back({e, d});
	endtask : op
	task automatic idle(input int n);
		repeat (n) op(0, 0, 8'h00, 8'h00, 4'h0);
	endtask : idle
	// random gating, polarity and sources, then read back both enables, the select and both status registers
	task automatic rnd_case;
		logic [7:0] e1, e2, p;
		logic act, g;
		logic [3:0] f;
		e1 = 8'($urandom);
		e2 = 8'($urandom);
		p = 8'($urandom);
		op(1, 0, OFS_ENABLE_ONE, e1, 0);
		op(1, 0, OFS_ENABLE_TWO, e2, 0);
		op(1, 0, OFS_KBD_RST_GATE, p, 0);
		s1 <= 8'($urandom);
		s2 <= 8'($urandom);
		idle(3);
		act = p[7] ? s2[4] : !s2[4];
		g = ~|((e1 & s1 & MASK_ONE) | (e2 & {3'b000, act, 2'b00, s2[1:0]}));
		f = {p[7], 1'b0, g, e2[6] & !g};
		op(0, 1, OFS_ENABLE_ONE, e1 & MASK_ONE, f);
		op(0, 1, OFS_ENABLE_TWO, e2 & MASK_TWO_WR, f);
		op(0, 1, OFS_KBD_RST_GATE, p & MASK_KBD_SEL, f);
		op(0, 1, OFS_STATUS_ONE, s1 & MASK_ONE, f);
		op(0, 1, OFS_STATUS_TWO, {3'b000, act, 2'b00, s2[1:0]}, f);
	endtask : rnd_case
	// monitor: compare each read slot with the oldest note
	always @(posedge i_clk_sys) begin
		rd_q <= rd;
		if (rd_q)
			check({ah, irq, gn, fr, rdata}, q.pop_front());
	end
	initial begin
		#200000;
		failures++;
		give_verdict;
	end
	initial begin
		void'($urandom(68601));
		repeat (20) @(posedge i_clk_sys);
		i_srst <= 0;
		// reset values, status write ignored, unmapped read
		op(1, 0, OFS_STATUS_ONE, 8'hff, 0);
		op(0, 1, OFS_ENABLE_ONE, RST_ENABLE_ONE, 4'h2);
		op(0, 1, OFS_ENABLE_TWO, RST_ENABLE_TWO, 4'h2);
		op(0, 1, OFS_KBD_RST_GATE, RST_KBD_RST_GATE, 4'h2);
		op(0, 1, OFS_STATUS_ONE, 8'h00, 4'h2);
		op(0, 1, 8'h00, 8'h00, 4'h2);
		repeat (40) rnd_case;
		// infrared edge, read-clear, and the interrupt path
		op(1, 0, OFS_ENABLE_ONE, 8'h00, 0);
		op(1, 0, OFS_ENABLE_TWO, 8'h44, 0);
		op(1, 0, OFS_KBD_RST_GATE, 8'h80, 0);
		op(1, 0, OFS_EVT_CLEAR, 8'h03, 0);
		op(1, 0, OFS_EVT_ENABLE, 8'h02, 0);
		s1 <= 8'h00;
		s2 <= 8'h00;
		idle(3);
		ir <= 1'b1;
		idle(3);
		op(0, 1, OFS_STATUS_TWO, 8'h04, 4'hd);
		op(0, 1, OFS_STATUS_TWO, 8'h00, 4'he);
		op(0, 1, OFS_EVT_STATUS, 8'h03, 4'he);
		op(0, 1, OFS_EVT_ENABLE, 8'h02, 4'he);
		op(1, 0, OFS_EVT_CLEAR, 8'h03, 0);
		op(0, 1, OFS_EVT_STATUS, 8'h00, 4'ha);
		idle(3);
		check({11'h000, seen != 16'h0000}, 12'h001);
		give_verdict;
	end
endmodule : tb_top
`default_nettype wire
